// ==== rtl/sac_pkg.sv ====
package sac_pkg;

	// Frame and result layout
	localparam int RES_W = 12;
	localparam int PAD_W = 4;
	localparam int FRAME_W = RES_W + PAD_W;
	localparam logic [PAD_W-1:0] PAD_BITS = 4'h0;
	localparam logic [RES_W-1:0] CODE_ZERO = 12'h000;
	localparam logic [RES_W-1:0] CODE_FULL = 12'hFFF;

	// Cycle timing, counted in serial clocks
	localparam int FIRST_SAMPLE_CLK = 5;
	localparam int SAMPLE_CLKS = 12;
	localparam int CONV_CLKS = 28;
	localparam int EXTRA_CLKS = 1;
	localparam int SHORT_CLKS = 5;
	localparam int CNT_W = 6;
	localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
	localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;
	localparam logic [CNT_W-1:0] SAMPLE_FIRST = CNT_W'(FIRST_SAMPLE_CLK);
	localparam logic [CNT_W-1:0] SAMPLE_LAST =
		CNT_W'(FIRST_SAMPLE_CLK + SAMPLE_CLKS - 1);
	localparam logic [CNT_W-1:0] FRAME_LAST = CNT_W'(FRAME_W);
	localparam logic [CNT_W-1:0] CONV_DONE = CNT_W'(FRAME_W + CONV_CLKS);
	localparam logic [CNT_W-1:0] CYCLE_END =
		CNT_W'(FRAME_W + CONV_CLKS + EXTRA_CLKS);
	localparam logic [CNT_W-1:0] SHORT_END = CNT_W'(SHORT_CLKS);

	// Select-low length classes for the input selector
	localparam int LOW_W = 4;
	localparam logic [LOW_W-1:0] LOW_ZERO = 4'h0;
	localparam logic [LOW_W-1:0] LOW_ONE = 4'h1;
	localparam logic [LOW_W-1:0] SHORT_MIN = 4'h4;
	localparam logic [LOW_W-1:0] SHORT_MAX = 4'h7;
	localparam logic [LOW_W-1:0] LOW_SAT = 4'h8;

	// Converter variants
	typedef enum logic [1:0] {
		SAC_VAR_SINGLE = 2'b00,
		SAC_VAR_DUAL = 2'b01,
		SAC_VAR_PSEUDO = 2'b10
	} sac_variant_e;

	// Host control modes
	typedef enum logic [1:0] {
		SAC_MODE_CS = 2'b00,
		SAC_MODE_FS = 2'b01,
		SAC_MODE_CS_FS = 2'b10
	} sac_mode_e;

	// Device cycle states
	typedef enum logic [1:0] {
		D_IDLE = 2'b00,
		D_ARMED = 2'b01,
		D_ACTIVE = 2'b10
	} sac_dstate_e;

	// Host sequencer states
	typedef enum logic [1:0] {
		H_IDLE = 2'b00,
		H_OPEN = 2'b01,
		H_RUN = 2'b10,
		H_GAP = 2'b11
	} sac_hstate_e;

endpackage : sac_pkg

// ==== rtl/sac_link_if.sv ====
`timescale 1ns/10ps
interface sac_link_if;

	// Link wires
	logic sclk;
	logic cs_n;
	logic frame_sync;
	logic serial_result_out;
	logic result_oe_n;
	wire result_line;

	// Released line reads low, as through a pull-down
	assign result_line = serial_result_out & ~result_oe_n;

	modport dev (
		input sclk,
		input cs_n,
		input frame_sync,
		output serial_result_out,
		output result_oe_n
	);

	modport host (
		output sclk,
		output cs_n,
		output frame_sync,
		input result_line
	);

endinterface : sac_link_if

// ==== rtl/sac_dev.sv ====
`timescale 1ns/10ps
module sac_dev
	import sac_pkg::*;
#(
	parameter sac_variant_e VARIANT = SAC_VAR_SINGLE
) (
	// Serial link, all logic on its clock
	sac_link_if.dev lnk,
	// Reset, synchronous to the link clock
	input wire logic i_rst,
	// Input levels as codes of full scale
	input wire logic [RES_W-1:0] i_analog_input_zero,
	input wire logic [RES_W-1:0] i_analog_input_one,
	// Status, link clock domain
	output logic o_input_selector,
	output logic o_sampling,
	output logic o_converting,
	output logic o_powered_down,
	output logic [RES_W-1:0] o_result_bits
);

	// Only the three known variants are served
	if (VARIANT != SAC_VAR_SINGLE && VARIANT != SAC_VAR_DUAL &&
		VARIANT != SAC_VAR_PSEUDO) begin : g_bad_variant
		$error("sac_dev: unknown variant");
	end

	sac_dstate_e state_q;
	sac_dstate_e state_d;
	logic cs_prev_q;
	logic fs_prev_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic [LOW_W-1:0] low_cnt_q;
	logic [FRAME_W-1:0] shift_q;
	logic out_bit_q;
	logic drive_q;
	logic [RES_W-1:0] sample_q;
	logic [RES_W-1:0] result_q;
	logic sel_q;
	logic asleep_q;
	logic sampling_q;
	logic converting_q;

	// Frame sync only exists on the single-input variant
	wire single = (VARIANT == SAC_VAR_SINGLE);
	wire dual = (VARIANT == SAC_VAR_DUAL);
	wire pseudo = (VARIANT == SAC_VAR_PSEUDO);
	wire fs_in = single ? lnk.frame_sync : 1'b1;

	// Control edges, seen at rising clock edges
	wire cs_fall = cs_prev_q & ~lnk.cs_n;
	wire cs_rise = ~cs_prev_q & lnk.cs_n;
	wire fs_rise = ~fs_prev_q & fs_in;
	wire fs_fall = fs_prev_q & ~fs_in;
	wire in_idle = (state_q == D_IDLE);
	wire in_armed = (state_q == D_ARMED);
	wire in_active = (state_q == D_ACTIVE);

	// Cycle start and MSB presentation
	wire start_cs = in_idle & cs_fall & fs_in;
	wire arm_cs = in_idle & cs_fall & ~fs_in;
	wire arm_fs = ~in_active & fs_rise & ~lnk.cs_n;
	wire start_fs = in_armed & fs_fall & ~lnk.cs_n;
	wire load = start_cs | arm_cs | arm_fs;
	wire go = start_cs | start_fs;
	wire release_ev = cs_rise | fs_rise;

	// Cycle milestones
	wire take_sample = in_active & (cnt_q == SAMPLE_LAST);
	wire conv_done = in_active & (cnt_q == CONV_DONE);
	wire abort = in_active & release_ev & ~conv_done;
	wire frame_end = in_active & (cnt_q == FRAME_LAST);
	wire shifting = in_active & (cnt_q < FRAME_LAST);
	wire stop_drive = release_ev | frame_end;

	// Select-low length classes
	wire long_sel = (low_cnt_q > SHORT_MAX);
	wire short_sel = (low_cnt_q >= SHORT_MIN) & ~long_sel;

	// Pseudo-differential input clamps at zero scale
	wire [RES_W:0] diff = {1'b0, i_analog_input_zero} -
		{1'b0, i_analog_input_one};
	wire [RES_W-1:0] pseudo_code = diff[RES_W] ? CODE_ZERO :
		diff[RES_W-1:0];
	wire [RES_W-1:0] chan_code = (dual & sel_q) ? i_analog_input_one :
		i_analog_input_zero;
	// Code equals input level (pseudo: zero input less one input), 000h at ground to FFFh below full
	wire [RES_W-1:0] sample_code = pseudo ? pseudo_code : chan_code;

	// Cycle counter, one per rising clock in the cycle
	assign cnt_d = go ? CNT_ONE :
		(in_active ? cnt_q + CNT_ONE : CNT_ZERO);

	// Next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			D_IDLE: begin
				if (start_cs)
					state_d = D_ACTIVE;
				else if (arm_cs | arm_fs)
					state_d = D_ARMED;
			end
			D_ARMED: begin
				if (start_fs)
					state_d = D_ACTIVE;
				else if (cs_rise)
					state_d = D_IDLE;
			end
			D_ACTIVE: begin
				if (conv_done | abort)
					state_d = D_IDLE;
			end
			default: begin
				state_d = D_IDLE;
			end
		endcase
	end

	// Edge history and cycle state
	always_ff @(posedge lnk.sclk) begin
		if (i_rst) begin
			cs_prev_q <= 1'b1;
			fs_prev_q <= 1'b1;
			state_q <= D_IDLE;
			cnt_q <= CNT_ZERO;
		end else begin
			cs_prev_q <= lnk.cs_n;
			fs_prev_q <= fs_in;
			state_q <= state_d;
			cnt_q <= cnt_d;
		end
	end

	// Output shifter; bits change only on rising clock edges
	always_ff @(posedge lnk.sclk) begin
		if (i_rst) begin
			shift_q <= {RES_W'(0), PAD_BITS};
			out_bit_q <= 1'b0;
			drive_q <= 1'b0;
		end else if (load) begin
			shift_q <= {result_q, PAD_BITS};
			out_bit_q <= result_q[RES_W-1];
			drive_q <= 1'b1;
		end else if (stop_drive) begin
			drive_q <= 1'b0;
		end else if (shifting) begin
			shift_q <= {shift_q[FRAME_W-2:0], 1'b0};
			out_bit_q <= shift_q[FRAME_W-2];
		end
	end

	// Sample at the close of the sampling window
	always_ff @(posedge lnk.sclk) begin
		if (i_rst)
			sample_q <= CODE_ZERO;
		else if (take_sample)
			sample_q <= sample_code;
	end

	// Result only moves on a finished conversion, so an
	// aborted cycle leaves the older result to be read again
	always_ff @(posedge lnk.sclk) begin
		if (i_rst)
			result_q <= CODE_ZERO;
		else if (conv_done)
			result_q <= sample_q;
	end

	// Length of the current select-low period, saturating
	always_ff @(posedge lnk.sclk) begin
		if (i_rst | lnk.cs_n)
			low_cnt_q <= LOW_ZERO;
		else if (low_cnt_q != LOW_SAT)
			low_cnt_q <= low_cnt_q + LOW_ONE;
	end

	// Input selector, dual-input variant only
	always_ff @(posedge lnk.sclk) begin
		if (i_rst) begin
			sel_q <= 1'b0;
		end else if (dual & cs_rise) begin
			if (long_sel)
				sel_q <= ~sel_q;
			else if (short_sel)
				sel_q <= 1'b0;
		end
	end

	// Power-down flag; asleep from reset until a load, and again after each finished conversion
	always_ff @(posedge lnk.sclk) begin
		if (i_rst)
			asleep_q <= 1'b1;
		else if (load)
			asleep_q <= 1'b0;
		else if (conv_done)
			asleep_q <= 1'b1;
	end

	// Phase flags, registered from the next count
	always_ff @(posedge lnk.sclk) begin
		if (i_rst) begin
			sampling_q <= 1'b0;
			converting_q <= 1'b0;
		end else begin
			sampling_q <= (state_d == D_ACTIVE) &
				(cnt_d >= SAMPLE_FIRST) & (cnt_d <= SAMPLE_LAST);
			converting_q <= (state_d == D_ACTIVE) &
				(cnt_d > FRAME_LAST);
		end
	end

	// Link outputs; select high overrides the driver at once
	assign lnk.serial_result_out = out_bit_q;
	assign lnk.result_oe_n = ~drive_q | lnk.cs_n;

	// Status outputs
	assign o_input_selector = sel_q;
	assign o_sampling = sampling_q;
	assign o_converting = converting_q;
	assign o_powered_down = asleep_q;
	assign o_result_bits = result_q;

endmodule : sac_dev

// ==== rtl/sac_host.sv ====
`timescale 1ns/10ps
module sac_host
	import sac_pkg::*;
#(
	parameter int HALF_PERIOD = 3,
	parameter int GAP_CLKS = 1
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_rst,
	// Serial link toward the converter
	sac_link_if.host lnk,
	// Request side
	input wire logic i_start,
	input wire logic [1:0] i_mode,
	input wire logic i_force_zero,
	output logic o_ready,
	// Answer side
	output logic o_busy,
	output logic [RES_W-1:0] o_result,
	output logic o_result_valid
);

	localparam int DIV_W = 8;
	localparam logic [DIV_W-1:0] DIV_ZERO = 8'h00;
	localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
	localparam logic [DIV_W-1:0] HALF_LAST = DIV_W'(HALF_PERIOD - 1);
	localparam logic [CNT_W-1:0] GAP_LAST = CNT_W'(GAP_CLKS);

	// Data must settle through the synchroniser before a fall
	if (HALF_PERIOD < 3 || HALF_PERIOD > 255) begin : g_bad_half
		$error("sac_host: HALF_PERIOD must be 3 to 255");
	end
	if (GAP_CLKS < 1 || GAP_CLKS > 63) begin : g_bad_gap
		$error("sac_host: GAP_CLKS must be 1 to 63");
	end

	sac_hstate_e state_q;
	sac_hstate_e state_d;
	logic [DIV_W-1:0] div_q;
	logic sclk_q;
	logic data_s1_q;
	logic data_s2_q;
	logic cs_n_q;
	logic fs_q;
	logic force_q;
	logic [1:0] mode_q;
	logic [CNT_W-1:0] k_q;
	logic [FRAME_W-2:0] shift_q;
	logic [RES_W-1:0] result_q;
	logic valid_q;

	// Serial clock ticks; clock runs free, starting low out of reset
	wire wrap = (div_q == HALF_LAST);
	wire fall_tick = wrap & sclk_q;

	// Sequencer decode
	wire take = (state_q == H_IDLE) & i_start;
	wire cs_path = (mode_q == SAC_MODE_CS) | force_q;
	wire fs_only = (mode_q == SAC_MODE_FS) & ~force_q;
	wire open_tick = (state_q == H_OPEN) & fall_tick;
	wire open_go = open_tick & (cs_path ? cs_n_q : (~cs_n_q & fs_q));
	wire run_tick = (state_q == H_RUN) & fall_tick;
	wire [CNT_W-1:0] k_next = k_q + CNT_ONE;
	wire [CNT_W-1:0] end_k = force_q ? SHORT_END : CYCLE_END;
	wire run_end = run_tick & (k_next == end_k);
	wire gap_end = (state_q == H_GAP) & fall_tick & (k_next == GAP_LAST);
	wire bit_tick = run_tick & (k_q < FRAME_LAST);
	wire word_tick = run_tick & (k_next == FRAME_LAST) & ~force_q;

	// Next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			H_IDLE: begin
				if (take)
					state_d = H_OPEN;
			end
			H_OPEN: begin
				if (open_go)
					state_d = H_RUN;
			end
			H_RUN: begin
				if (run_end)
					state_d = H_GAP;
			end
			H_GAP: begin
				if (gap_end)
					state_d = H_IDLE;
			end
			default: begin
				state_d = H_IDLE;
			end
		endcase
	end

	// Clock divider, drives the link clock
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			div_q <= DIV_ZERO;
			sclk_q <= 1'b0;
		end else if (wrap) begin
			div_q <= DIV_ZERO;
			sclk_q <= ~sclk_q;
		end else begin
			div_q <= div_q + DIV_ONE;
		end
	end

	// Result line synchroniser
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			data_s1_q <= 1'b0;
			data_s2_q <= 1'b0;
		end else begin
			data_s1_q <= lnk.result_line;
			data_s2_q <= data_s1_q;
		end
	end

	// State, request latch and tick counter
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_q <= H_IDLE;
			mode_q <= SAC_MODE_CS;
			force_q <= 1'b0;
			k_q <= CNT_ZERO;
		end else begin
			state_q <= state_d;
			if (take) begin
				mode_q <= i_mode;
				force_q <= i_force_zero;
			end
			if (open_go | run_end)
				k_q <= CNT_ZERO;
			else if (run_tick | (state_q == H_GAP && fall_tick))
				k_q <= k_next;
		end
	end

	// Control lines change with the falling clock
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			cs_n_q <= 1'b1;
			fs_q <= 1'b1;
		end else if (open_tick & cs_path) begin
			cs_n_q <= ~cs_n_q;
			fs_q <= 1'b1;
		end else if (open_tick) begin
			cs_n_q <= 1'b0;
			fs_q <= ~cs_n_q & ~fs_q;
		end else if (run_end) begin
			cs_n_q <= ~fs_only;
			fs_q <= 1'b1;
		end
	end

	// Capture on falling edges, MSB first
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			shift_q <= '0;
			result_q <= CODE_ZERO;
			valid_q <= 1'b0;
		end else begin
			valid_q <= word_tick;
			if (bit_tick)
				shift_q <= {shift_q[FRAME_W-3:0], data_s2_q};
			if (word_tick)
				result_q <= shift_q[FRAME_W-2:PAD_W-1];
		end
	end

	// Outputs
	assign lnk.sclk = sclk_q;
	assign lnk.cs_n = cs_n_q;
	assign lnk.frame_sync = fs_q;
	assign o_ready = (state_q == H_IDLE);
	assign o_busy = (state_q != H_IDLE);
	assign o_result = result_q;
	assign o_result_valid = valid_q;

endmodule : sac_host

// ==== bench/sac_link_asserts.sv ====
`timescale 1ns/10ps
module sac_link_asserts (
	// Link clock and device reset
	input wire logic sclk,
	input wire logic i_rst,
	// Link signals
	input wire logic cs_n,
	input wire logic serial_result_out,
	input wire logic result_oe_n
);
	logic [5:0] cnt_q;
	logic [5:0] cnt_d;
	logic fall_bit_q;
	// Rising edges with select low; saturates so long holds cannot wrap
	assign cnt_d = cs_n ? 6'h00 : (cnt_q == 6'h3F ? cnt_q : cnt_q + 6'h01);
	always_ff @(posedge sclk) begin
		if (i_rst) begin
			cnt_q <= 6'h00;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	// Bit as the host captures it
	always_ff @(negedge sclk) begin
		fall_bit_q <= serial_result_out;
	end
	default clocking cb @(posedge sclk); endclocking
	default disable iff (i_rst);
	// Output enable and data relations on the wire
	a_desel_off: assert property (cs_n |-> result_oe_n)
		else $error("result line driven while deselected");
	a_no_early: assert property (!cs_n && cnt_q == 6'h00 |-> result_oe_n)
		else $error("result line driven before select fall seen");
	a_frame_drive: assert property (!cs_n && cnt_q >= 6'h01
		&& cnt_q <= 6'h10 |-> !result_oe_n)
		else $error("result line not driven inside frame");
	a_frame_release: assert property (!cs_n && cnt_q >= 6'h11
		|-> result_oe_n)
		else $error("result line not released after sixteen bits");
	a_pad_zero: assert property (!cs_n && cnt_q >= 6'h0D
		&& cnt_q <= 6'h10 |-> !serial_result_out)
		else $error("filler bit not zero");
	a_fall_stable: assert property (!cs_n && cnt_q >= 6'h01
		|-> serial_result_out == fall_bit_q)
		else $error("data bit changed away from rising edge");
	a_hold_cycle: assert property ($rose(cs_n)
		|-> cnt_q inside {[6'h04:6'h07], 6'h2D})
		else $error("select low length neither short nor full cycle");
	a_gap_high: assert property ($rose(cs_n) |=> cs_n)
		else $error("no clock edge while select high");
endmodule : sac_link_asserts

// ==== bench/sar_adc_serial_control_tb_top.sv ====
`timescale 1ns/10ps
`define CHK(nm, ex, gt) begin \
	checked++; \
	if ((gt) !== (ex)) begin \
		num_errors++; \
		$display("ERROR %s exp %0h got %0h", nm, ex, gt); \
	end \
end
module sar_adc_serial_control_tb_top import sac_pkg::*;;
	// Clock, resets and stimulus
	logic i_clk_sys = 1'b0;
	logic rst_sys = 1'b1;
	logic rst_dev = 1'b1;
	logic start = 1'b0;
	logic force_zero = 1'b0;
	logic [RES_W-1:0] analog_input_zero = 12'h000;
	logic [RES_W-1:0] analog_input_one = 12'h000;
	logic [1:0] mode = 2'h0;
	// Design outputs
	logic rdy, busy, rvalid, sel_o, smp_o, conv_o, pdn_o;
	logic [RES_W-1:0] res_o, bits_o;
	logic rdy_fs, pdn_fs;
	logic [RES_W-1:0] res_fs, bits_fs;
	// Single-input model: queue of samples awaiting readout
	logic [RES_W-1:0] exp_fs;
	logic [RES_W-1:0] q_fs[$];
	// Reference model state and bookkeeping
	logic [RES_W-1:0] exp_res = 12'h000;
	logic [RES_W-1:0] smp;
	logic exp_sel = 1'b0;
	logic [FRAME_W-1:0] wire_sh;
	int wire_n = 0, n_valid = 0, n_smp = 0, n_conv = 0, nv, cyc = 0;
	int num_errors = 0, checked = 0, seed = 47;

	sac_link_if lnk ();
	sac_host i_sac_host (.i_clk_sys(i_clk_sys), .i_rst(rst_sys),
		.lnk(lnk.host), .i_start(start), .i_mode(2'h0),
		.i_force_zero(force_zero), .o_ready(rdy), .o_busy(busy),
		.o_result(res_o), .o_result_valid(rvalid));
	sac_dev #(.VARIANT(SAC_VAR_DUAL)) i_sac_dev (.lnk(lnk.dev),
		.i_rst(rst_dev), .i_analog_input_zero(analog_input_zero),
		.i_analog_input_one(analog_input_one), .o_input_selector(sel_o),
		.o_sampling(smp_o), .o_converting(conv_o),
		.o_powered_down(pdn_o), .o_result_bits(bits_o));
	sac_link_asserts i_sac_link_asserts (.sclk(lnk.sclk), .i_rst(rst_dev),
		.cs_n(lnk.cs_n), .serial_result_out(lnk.serial_result_out),
		.result_oe_n(lnk.result_oe_n));
	// Second pair: single-input converter under all three control modes
	sac_link_if lnk_fs ();
	sac_host i_sac_host_fs (.i_clk_sys(i_clk_sys), .i_rst(rst_sys),
		.lnk(lnk_fs.host), .i_start(start), .i_mode(mode),
		.i_force_zero(force_zero), .o_ready(rdy_fs), .o_busy(),
		.o_result(res_fs), .o_result_valid());
	sac_dev #(.VARIANT(SAC_VAR_SINGLE)) i_sac_dev_fs (.lnk(lnk_fs.dev),
		.i_rst(rst_dev), .i_analog_input_zero(analog_input_zero),
		.i_analog_input_one(analog_input_one), .o_input_selector(),
		.o_sampling(), .o_converting(),
		.o_powered_down(pdn_fs), .o_result_bits(bits_fs));

	always #10 i_clk_sys = ~i_clk_sys;

	// Frame start seen at a rise, so a select edge at a fall never races
	always @(posedge lnk.sclk) begin
		if (lnk.cs_n === 1'b1) wire_n = 0;
		else if (wire_n == 0) wire_n = 1;
	end
	// Capture at the falling edge, as a host does; phase flags are
	// read here too, away from the rising edge that moves them
	always @(negedge lnk.sclk) begin
		n_smp += (smp_o === 1'b1);
		n_conv += (conv_o === 1'b1);
		if (wire_n > 0 && wire_n <= FRAME_W) begin
			wire_sh = {wire_sh[FRAME_W-2:0], lnk.result_line};
			wire_n++;
		end
	end
	// Result pulses and hang guard
	always @(posedge i_clk_sys) begin
		cyc++;
		if (rvalid === 1'b1) n_valid++;
		if (cyc == 20000) begin
			num_errors++;
			close_out();
		end
	end

	task automatic close_out();
		if (num_errors == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out

	// One request, then wait for the host to go idle again
	task automatic frame(input logic fz);
		int k;
		nv = n_valid;
		n_smp = 0;
		n_conv = 0;
		@(posedge i_clk_sys);
		#1;
		start = 1'b1;
		force_zero = fz;
		@(posedge i_clk_sys);
		#1;
		start = 1'b0;
		k = 0;
		while ((rdy & rdy_fs) !== 1'b1 && k < 2000) begin
			@(posedge i_clk_sys);
			#1;
			k++;
		end
		`CHK("ready", 1'b1, rdy & rdy_fs);
	endtask : frame

	// Full cycles back to back, with short selector resets between
	initial begin
		q_fs.push_back(CODE_ZERO);
		repeat (12) @(posedge i_clk_sys);
		#1 rst_sys = 1'b0;
		repeat (24) @(posedge i_clk_sys);
		#1 rst_dev = 1'b0;
		`CHK("pdn", 1'b1, pdn_o);
		`CHK("sel", 1'b0, sel_o);
		for (int i = 0; i < 12; i++) begin
			mode = 2'(i % 3);
			if (i == 4 || i == 8) begin
				frame(1'b1);
				exp_sel = 1'b0;
				`CHK("sel", exp_sel, sel_o);
				`CHK("nvalid", nv, n_valid);
				`CHK("hold", exp_res, bits_o);
				`CHK("hold_fs", q_fs[0], bits_fs);
			end
			analog_input_zero = i == 0 ? CODE_ZERO : 12'($random(seed));
			analog_input_one = i == 0 ? CODE_FULL : 12'($random(seed));
			smp = exp_sel ? analog_input_one : analog_input_zero;
			q_fs.push_back(analog_input_zero);
			frame(1'b0);
			`CHK("res", exp_res, res_o);
			`CHK("wire", {exp_res, PAD_BITS}, wire_sh);
			`CHK("valid", nv + 1, n_valid);
			`CHK("bits", smp, bits_o);
			`CHK("pdn", 1'b1, pdn_o);
			`CHK("smp", SAMPLE_CLKS, n_smp);
			`CHK("conv", CONV_CLKS, n_conv);
			exp_sel = ~exp_sel;
			`CHK("sel", exp_sel, sel_o);
			exp_res = smp;
			exp_fs = q_fs.pop_front();
			`CHK("res_fs", exp_fs, res_fs);
			`CHK("bits_fs", q_fs[0], bits_fs);
			`CHK("pdn_fs", mode != 2'h1, pdn_fs);
		end
		close_out();
	end
endmodule : sar_adc_serial_control_tb_top
